// ==== shared/scpf_consts.vh ====
// constants for the serial pin and frame control block
// Contract
// - enabled module drives transmit pin as output, except in loop mode
// - enabled module takes receive pin as input
// - tx disabled: pin released after frame ends
// - tx enabled: idle high, plain or infrared
// - rx enabled samples pin; far end idles high
// - module disabled: pins back to port
// - loop feeds tx output into receiver
// - loop path bypasses infrared coding
// - disable sets empty, complete; masks tx irq
// - length bit selects nine or eight bits
// - wake bit selects address mark or idle
// - idle type picks count start point
// - parity placed in character msb
// - parity type odd when set, even clear
// - one start, one stop; 10 or 11 bits
// - parity frames: 7 or 8 data plus parity
// - tx empty enable gates tx interrupt
// - tx complete enable gates tx interrupt
// - rx full enable gates rx interrupt
// - reset clears all control bits here
// - cleared tx enable finishes current character
// - address mark clears standby, sets rx full
// - idle is 10 or 11 ones
`ifndef SCPF_CONSTS_VH
`define SCPF_CONSTS_VH
`define SCPF_ADR_CTRL1    4'h0
`define SCPF_ADR_CTRL2    4'h4
`define SCPF_ADR_DATA     4'h8
`define SCPF_ADR_STAT     4'hC
`define SCPF_ADR_BAUD     4'h0
// control one
`define SCPF_C1_LOOP      7
`define SCPF_C1_EN        6
`define SCPF_C1_IR        5
`define SCPF_C1_LEN9      4
`define SCPF_C1_WAKE      3
`define SCPF_C1_IDLE_COUNT_TYPE      2
`define SCPF_C1_PEN       1
`define SCPF_C1_PODD      0
// control two
`define SCPF_C2_TEIE      7
`define SCPF_C2_TX_COMPLETE_IRQ_ENABLE      6
`define SCPF_C2_RFIE      5
`define SCPF_C2_TXEN      3
`define SCPF_C2_RXEN      2
`define SCPF_C2_STBY      1
`define SCPF_C2_BIT8      0
// status
`define SCPF_ST_TE        7
`define SCPF_ST_TC        6
`define SCPF_ST_RF        5
`define SCPF_ST_IDLE      4
`define SCPF_ST_PERR      3
`define SCPF_ST_FERR      2
`define SCPF_ST_RX8       1
`define SCPF_RESET_CTRL   8'h00
`define SCPF_BAUD_DIV     16'h0010
`endif

// ==== src/scpf_top.v ====
// serial pin steering, frame format and interrupt gating with a small uart core
`timescale 1ns/1ns
`default_nettype none
`include "scpf_consts.vh"
module scpf_top #(
  parameter [15:0] BAUD_DIV = `SCPF_BAUD_DIV
) (
  input  wire        sys_clk,
  input  wire        rst_n,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [3:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  output reg         wb_err_o,
  input  wire        serial_tx_pin_i,
  output reg         serial_tx_pin_o,
  output reg         serial_tx_pin_oe_n,
  input  wire        serial_rx_pin_i,
  output reg         serial_rx_pin_o,
  output reg         serial_rx_pin_oe_n,
  input  wire        port_dir_bit_six,
  input  wire        port_dir_bit_seven,
  input  wire        port_out_six,
  input  wire        port_out_seven,
  output reg         port_in_six,
  output reg         port_in_seven,
  output reg         tx_irq,
  output reg         rx_irq
);
  localparam TX_IDLE = 2'd0;
  localparam TX_SHIFT = 2'd1;
  localparam RX_IDLE = 2'd0;
  localparam RX_SHIFT = 2'd1;

  reg [7:0]  ctrl1_r;
  reg [7:0]  ctrl2_r;
  reg [7:0]  tx_data_r;
  reg [7:0]  rx_data_r;
  reg        tx_empty_flag_r;
  reg        tx_complete_flag_r;
  reg        rx_full_flag_r;
  reg        idle_flag_r;
  reg        perr_r;
  reg        ferr_r;
  reg        rx8_r;
  reg [1:0]  tx_st_r;
  reg [10:0] tx_sh_r;
  reg [3:0]  tx_cnt_r;
  reg [15:0] tx_div_r;
  reg        tx_line_r;
  reg [1:0]  rx_st_r;
  reg [15:0] rx_div_r;
  reg [3:0]  rx_cnt_r;
  reg [9:0]  rx_sh_r;
  reg [3:0]  ones_r;
  reg        idle_seen_r;
  reg [1:0]  rx_sync_r;
  reg [1:0]  txp_sync_r;

  wire module_enable = ctrl1_r[`SCPF_C1_EN];
  wire loopback_select = ctrl1_r[`SCPF_C1_LOOP];
  wire infrared_enable = ctrl1_r[`SCPF_C1_IR];
  wire len9 = ctrl1_r[`SCPF_C1_LEN9];
  wire wake_addr = ctrl1_r[`SCPF_C1_WAKE];
  wire idle_count_type = ctrl1_r[`SCPF_C1_IDLE_COUNT_TYPE];
  wire parity_enable = ctrl1_r[`SCPF_C1_PEN];
  wire parity_odd_select = ctrl1_r[`SCPF_C1_PODD];
  wire transmit_enable = ctrl2_r[`SCPF_C2_TXEN];
  wire receive_enable = ctrl2_r[`SCPF_C2_RXEN];
  wire rx_standby = ctrl2_r[`SCPF_C2_STBY];
  wire [3:0] frame_bits = len9 ? 4'd11 : 4'd10;

  wire bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
  wire adr_ok = (wb_adr_i[1:0] == 2'b00);
  wire wr = bus_req & wb_we_i & adr_ok & wb_sel_i[0];
  wire rd = bus_req & ~wb_we_i & adr_ok;
  wire wr_c1 = wr & (wb_adr_i == `SCPF_ADR_CTRL1);
  wire wr_c2 = wr & (wb_adr_i == `SCPF_ADR_CTRL2);
  wire wr_dat = wr & (wb_adr_i == `SCPF_ADR_DATA);
  wire rd_dat = rd & (wb_adr_i == `SCPF_ADR_DATA);
  wire tx_load;
  wire rx_wake;

  // infrared: a zero becomes a short low pulse in the last sixteenth of the bit, since tx_line_r lags the divider by one cycle
  wire ir_pulse = (tx_div_r < {4'd0, BAUD_DIV[15:4]});
  wire tx_serial = tx_line_r;
  wire tx_coded = infrared_enable ? (tx_serial | ~ir_pulse) : tx_serial;
  wire tx_busy = (tx_st_r != TX_IDLE);
  // receiver input: loop skips both the pin and the infrared encoder
  wire rx_in = loopback_select ? tx_serial : rx_sync_r[1];
  wire rx_active = module_enable & receive_enable;

  wire [8:0] tx_char = {ctrl2_r[`SCPF_C2_BIT8], tx_data_r};
  wire par7 = ^tx_data_r[6:0] ^ parity_odd_select;
  wire par8 = ^tx_data_r ^ parity_odd_select;
  wire [8:0] tx_word = !parity_enable ? tx_char :
                       len9 ? {par8, tx_data_r} : {1'b0, par7, tx_data_r[6:0]};

  // bus slave, one cycle answer
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= bus_req & adr_ok;
      wb_err_o <= bus_req & ~adr_ok;
      wb_dat_o <= 32'h0000_0000;
      if (rd) begin
        case (wb_adr_i)
          `SCPF_ADR_CTRL1: wb_dat_o <= {24'h00_0000, ctrl1_r};
          `SCPF_ADR_CTRL2: wb_dat_o <= {24'h00_0000, ctrl2_r};
          `SCPF_ADR_DATA:  wb_dat_o <= {24'h00_0000, rx_data_r};
          default: wb_dat_o <= {24'h00_0000, tx_empty_flag_r, tx_complete_flag_r,
                                rx_full_flag_r, idle_flag_r, perr_r, ferr_r, rx8_r, 1'b0};
        endcase
      end
    end
  end

  // control registers and flags
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl1_r <= `SCPF_RESET_CTRL;
      ctrl2_r <= `SCPF_RESET_CTRL;
      tx_data_r <= 8'h00;
      tx_empty_flag_r <= 1'b1;
      tx_complete_flag_r <= 1'b1;
    end else begin
      if (wr_c1)
        ctrl1_r <= wb_dat_i[7:0];
      if (wr_c2) begin
        ctrl2_r <= wb_dat_i[7:0];
        // enables only change while the module is on
        if (!module_enable) begin
          ctrl2_r[`SCPF_C2_TXEN] <= ctrl2_r[`SCPF_C2_TXEN];
          ctrl2_r[`SCPF_C2_RXEN] <= ctrl2_r[`SCPF_C2_RXEN];
        end
      end else if (rx_wake) begin
        ctrl2_r[`SCPF_C2_STBY] <= 1'b0;
      end
      if (wr_dat) begin
        tx_data_r <= wb_dat_i[7:0];
        tx_empty_flag_r <= 1'b0;
      end
      if (tx_load)
        tx_empty_flag_r <= 1'b1;
      tx_complete_flag_r <= tx_empty_flag_r & ~tx_busy & ~tx_load & ~wr_dat;
      if (!module_enable) begin
        tx_empty_flag_r <= 1'b1;
        tx_complete_flag_r <= 1'b1;
      end
    end
  end

  // transmitter
  assign tx_load = (tx_st_r == TX_IDLE) & module_enable & transmit_enable & ~tx_empty_flag_r;
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_st_r <= TX_IDLE;
      tx_sh_r <= 11'h7FF;
      tx_cnt_r <= 4'd0;
      tx_div_r <= 16'h0000;
      tx_line_r <= 1'b1;
    end else begin
      case (tx_st_r)
        TX_IDLE: begin
          tx_line_r <= 1'b1;
          tx_div_r <= 16'h0000;
          if (tx_load) begin
            tx_sh_r <= len9 ? {1'b1, tx_word, 1'b0} : {2'b11, tx_word[7:0], 1'b0};
            tx_cnt_r <= frame_bits;
            tx_st_r <= TX_SHIFT;
          end
        end
        TX_SHIFT: begin
          // the frame runs out even if the enable falls meanwhile
          tx_line_r <= tx_sh_r[0];
          if (tx_div_r == BAUD_DIV - 16'd1) begin
            tx_div_r <= 16'h0000;
            tx_sh_r <= {1'b1, tx_sh_r[10:1]};
            tx_cnt_r <= tx_cnt_r - 4'd1;
            if (tx_cnt_r == 4'd1)
              tx_st_r <= TX_IDLE;
          end else begin
            tx_div_r <= tx_div_r + 16'd1;
          end
        end
        default: tx_st_r <= TX_IDLE;
      endcase
    end
  end

  // receiver
  wire rx_mid = (rx_div_r == {1'b0, BAUD_DIV[15:1]});
  wire rx_last = (rx_st_r == RX_SHIFT) & rx_mid & (rx_cnt_r == 4'd1);
  wire [8:0] rx_char = len9 ? rx_sh_r[9:1] : {1'b0, rx_sh_r[9:2]};
  wire rx_msb = len9 ? rx_char[8] : rx_char[7];
  wire rx_perr = parity_enable & ((len9 ? ^rx_char[8:0] : ^rx_char[7:0]) ^ parity_odd_select);
  assign rx_wake = rx_active & rx_standby &
                   (wake_addr ? (rx_last & rx_msb) : (ones_r == frame_bits) & ~idle_seen_r);
  wire rx_deliver = rx_active & rx_last & (~rx_standby | (wake_addr & rx_msb));
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_sync_r <= 2'b11;
      txp_sync_r <= 2'b11;
      rx_st_r <= RX_IDLE;
      rx_div_r <= 16'h0000;
      rx_cnt_r <= 4'd0;
      rx_sh_r <= 10'h000;
      ones_r <= 4'd0;
      idle_seen_r <= 1'b0;
      rx_data_r <= 8'h00;
      rx_full_flag_r <= 1'b0;
      idle_flag_r <= 1'b0;
      perr_r <= 1'b0;
      ferr_r <= 1'b0;
      rx8_r <= 1'b0;
    end else begin
      rx_sync_r <= {rx_sync_r[0], serial_rx_pin_i};
      txp_sync_r <= {txp_sync_r[0], serial_tx_pin_i};
      if (rd_dat) begin
        rx_full_flag_r <= 1'b0;
        idle_flag_r <= 1'b0;
      end
      if (!rx_active) begin
        rx_st_r <= RX_IDLE;
        ones_r <= 4'd0;
      end else begin
        case (rx_st_r)
          RX_IDLE: begin
            if (!rx_in) begin
              rx_st_r <= RX_SHIFT;
              rx_div_r <= 16'h0000;
              rx_cnt_r <= frame_bits;
              ones_r <= 4'd0;
              idle_seen_r <= 1'b0;
            end
          end
          RX_SHIFT: begin
            rx_div_r <= (rx_div_r == BAUD_DIV - 16'd1) ? 16'h0000 : rx_div_r + 16'd1;
            if (rx_mid) begin
              rx_sh_r <= {rx_in, rx_sh_r[9:1]};
              rx_cnt_r <= rx_cnt_r - 4'd1;
              // count ones from after the start bit, or from the stop bit on
              if (!idle_count_type && rx_cnt_r != frame_bits)
                ones_r <= rx_in ? ones_r + 4'd1 : 4'd0;
              if (rx_cnt_r == 4'd1)
                rx_st_r <= RX_IDLE;
            end
          end
          default: rx_st_r <= RX_IDLE;
        endcase
        // ones seen on an idle line, one per bit time; a start bit keeps the
        // divider phase cleared above, so bits are sampled mid-cell
        if (rx_st_r == RX_IDLE && rx_in) begin
          rx_div_r <= (rx_div_r == BAUD_DIV - 16'd1) ? 16'h0000 : rx_div_r + 16'd1;
          if (rx_in && rx_div_r == BAUD_DIV - 16'd1 && ones_r != frame_bits)
            ones_r <= ones_r + 4'd1;
        end
        if (ones_r == frame_bits && !idle_seen_r) begin
          idle_seen_r <= 1'b1;
          if (!rx_standby)
            idle_flag_r <= 1'b1;
        end
        if (rx_deliver) begin
          rx_data_r <= rx_char[7:0];
          rx8_r <= len9 ? rx_char[8] : rx_char[7];
          rx_full_flag_r <= 1'b1;
          perr_r <= rx_perr;
          ferr_r <= ~rx_in;
        end
      end
    end
  end

  // pins, port routing and interrupt requests
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      serial_tx_pin_o <= 1'b0;
      serial_tx_pin_oe_n <= 1'b1;
      serial_rx_pin_o <= 1'b0;
      serial_rx_pin_oe_n <= 1'b1;
      port_in_six <= 1'b1;
      port_in_seven <= 1'b1;
      tx_irq <= 1'b0;
      rx_irq <= 1'b0;
    end else begin
      port_in_six <= txp_sync_r[1];
      port_in_seven <= rx_sync_r[1];
      if (module_enable) begin
        // open drain: only a low is driven, high is left to the pullup
        serial_tx_pin_o <= 1'b0;
        serial_tx_pin_oe_n <= ((transmit_enable | tx_busy) & !loopback_select) ?
                              tx_coded : 1'b1;
        serial_rx_pin_o <= 1'b0;
        serial_rx_pin_oe_n <= 1'b1;
      end else begin
        serial_tx_pin_o <= 1'b0;
        serial_tx_pin_oe_n <= ~(port_dir_bit_six & ~port_out_six);
        serial_rx_pin_o <= 1'b0;
        serial_rx_pin_oe_n <= ~(port_dir_bit_seven & ~port_out_seven);
      end
      tx_irq <= module_enable & ((ctrl2_r[`SCPF_C2_TEIE] & tx_empty_flag_r) |
                (ctrl2_r[`SCPF_C2_TX_COMPLETE_IRQ_ENABLE] & tx_complete_flag_r));
      rx_irq <= ~rx_standby & ctrl2_r[`SCPF_C2_RFIE] & rx_full_flag_r;
    end
  end
endmodule // scpf_top
`default_nettype wire

// ==== verif/scpf_checker.sv ====
// port assertions for the serial pin and frame control block
`timescale 1ns/1ns
`default_nettype none
module scpf_checker (
  input wire        sys_clk,
  input wire        rst_n,
  input wire        wb_cyc_i,
  input wire        wb_stb_i,
  input wire        wb_we_i,
  input wire [3:0]  wb_adr_i,
  input wire [3:0]  wb_sel_i,
  input wire [31:0] wb_dat_i,
  input wire        wb_ack_o,
  input wire        wb_err_o,
  input wire        serial_tx_pin_oe_n,
  input wire        serial_rx_pin_oe_n,
  input wire        port_dir_bit_six,
  input wire        port_out_six,
  input wire        tx_irq,
  input wire        rx_irq
);
  // control shadows follow acked writes; pins and irqs change on the same edge as the shadows
  reg  [7:0] c1_r;
  reg  [7:0] c2_r;
  wire       wr_ok = wb_ack_o & wb_we_i & wb_sel_i[0];
  wire       req = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      c1_r <= 8'h00;
      c2_r <= 8'h00;
    end else begin
      if (wr_ok && wb_adr_i == 4'h0) c1_r <= wb_dat_i[7:0];
      if (wr_ok && wb_adr_i == 4'h4) c2_r <= wb_dat_i[7:0];
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  chk_ack_latency: assert property (req |=> wb_ack_o || wb_err_o)
    else $error("request not answered");
  chk_misaligned_err: assert property (req && wb_adr_i[1:0] != 2'b00 |=> wb_err_o && !wb_ack_o)
    else $error("misaligned access not refused");
  chk_rx_input: assert property (c1_r[6] && $past(c1_r[6]) |-> serial_rx_pin_oe_n)
    else $error("receive pin driven while enabled");
  chk_port_tx: assert property (!c1_r[6] && !$past(c1_r[6])
    |-> serial_tx_pin_oe_n == (!$past(port_dir_bit_six) || $past(port_out_six)))
    else $error("transmit pin not under port control");
  chk_loop_release: assert property (c1_r[7:6] == 2'b11 && $past(c1_r[7:6]) == 2'b11
    |-> serial_tx_pin_oe_n)
    else $error("transmit pin driven in loop mode");
  chk_start_width: assert property (c1_r[6:5] == 2'b10 && $fell(serial_tx_pin_oe_n)
    |-> !serial_tx_pin_oe_n [*8])
    else $error("plain low bit too short");
  chk_ir_pulse: assert property (c1_r[6:5] == 2'b11 && $fell(serial_tx_pin_oe_n)
    |-> ##[1:2] serial_tx_pin_oe_n)
    else $error("infrared pulse too long");
  chk_tx_irq_mask: assert property (c2_r[7:6] == 2'b00 && $past(c2_r[7:6]) == 2'b00
    |-> !tx_irq)
    else $error("tx irq while masked");
  chk_off_no_txirq: assert property (!c1_r[6] && !$past(c1_r[6]) |-> !tx_irq)
    else $error("tx irq while module off");
  chk_rx_irq_mask: assert property (!c2_r[5] && !$past(c2_r[5]) |-> !rx_irq)
    else $error("rx irq while masked");
  cov_loop_rx: cover property (c1_r[7] && rx_irq);
  cov_ir_pulse: cover property (c1_r[5] && $fell(serial_tx_pin_oe_n));
  cov_tx_irq: cover property (tx_irq);
endmodule // scpf_checker
bind scpf_top scpf_checker u_chk (
  .sys_clk, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
  .wb_ack_o, .wb_err_o, .serial_tx_pin_oe_n, .serial_rx_pin_oe_n, .port_dir_bit_six,
  .port_out_six, .tx_irq, .rx_irq);
`default_nettype wire

// ==== verif/scpf_remote.sv ====
// far-end serial transmitter driving the receive line
`timescale 1ns/1ns
`default_nettype none
module scpf_remote (
  input  wire  sys_clk,
  output logic line
);
  initial line = 1'b1; // idle high between frames
  // start 0, data lsb first, stop 1; a larger bit_len models a slow far end
  task automatic send(input logic [8:0] data, input int nbits, input int bit_len);
    for (int i = 0; i < nbits + 2; i++) begin
      @(posedge sys_clk);
      line <= (i == 0) ? 1'b0 : (i > nbits) ? 1'b1 : data[i-1];
      repeat (bit_len - 1) @(posedge sys_clk);
    end
  endtask
endmodule // scpf_remote
`default_nettype wire

// ==== verif/tb_sci_pin_and_frame_control.sv ====
// self-checking bench for the serial pin and frame control block
`timescale 1ns/1ns
`default_nettype none
module tb_sci_pin_and_frame_control;
  typedef struct packed {logic [3:0] adr; logic [7:0] wd; logic [7:0] rd;} scpf_row_t;
  logic        sys_clk, rst_n, wb_cyc_i, wb_stb_i, wb_we_i;
  logic [3:0]  wb_adr_i, wb_sel_i;
  logic [31:0] wb_dat_i, q;
  logic        bus_err;
  logic        port_dir_bit_six, port_dir_bit_seven, port_out_six, port_out_seven;
  wire  [31:0] wb_dat_o;
  wire         wb_ack_o, wb_err_o, serial_tx_pin_o, serial_tx_pin_oe_n, serial_rx_pin_o;
  wire         serial_rx_pin_oe_n, port_in_six, port_in_seven, tx_irq, rx_irq, rem_line;
  // open-drain pins: pulled up unless a party pulls low
  wire         tx_wire = serial_tx_pin_oe_n | serial_tx_pin_o;
  wire         rx_wire = rem_line & (serial_rx_pin_oe_n | serial_rx_pin_o);
  int          n_errors, samples_checked, cycles, n;
  // enables written while the module is off must not stick
  scpf_row_t   rows [6] = '{'{4'h0, 8'h1F, 8'h1F}, '{4'h0, 8'hA0, 8'hA0}, '{4'h4, 8'h0C, 8'h00},
                            '{4'h4, 8'hE0, 8'hE0}, '{4'h4, 8'h00, 8'h00}, '{4'h0, 8'h00, 8'h00}};
  // odd select, byte sent, parity error expected
  logic [9:0]  prow [4] = '{{1'b0, 8'h3C, 1'b0}, {1'b1, 8'hBC, 1'b0}, {1'b0, 8'hBC, 1'b1},
                            {1'b1, 8'h3C, 1'b1}};
  scpf_top #(.BAUD_DIV(16'h0010)) dut (
    .sys_clk, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .wb_err_o, .serial_tx_pin_i(tx_wire), .serial_tx_pin_o,
    .serial_tx_pin_oe_n, .serial_rx_pin_i(rx_wire), .serial_rx_pin_o, .serial_rx_pin_oe_n,
    .port_dir_bit_six, .port_dir_bit_seven, .port_out_six, .port_out_seven, .port_in_six,
    .port_in_seven, .tx_irq, .rx_irq);
  scpf_remote rem (.sys_clk, .line(rem_line));
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 30000) begin
      n_errors++;
      print_verdict();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one classic cycle; read data is taken at the ack edge
  task automatic bus(input logic we, input logic [3:0] adr, input logic [7:0] d);
    @(posedge sys_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= {24'h00_0000, d};
    // no limit of its own: the cycle counter ends a hung wait
    do begin
      @(posedge sys_clk);
    end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1);
    q = wb_dat_o;
    bus_err = wb_err_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic poll_tc;
    n = 0;
    do begin
      bus(1'b0, 4'hC, 8'h00);
      n++;
    end while (q[6] !== 1'b1 && n < 300);
    chk(q[6], 1'b1);
  endtask
  initial begin
    rst_n = 1'b0;
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = '0;
    wb_sel_i = 4'hF;
    {port_dir_bit_six, port_dir_bit_seven, port_out_six, port_out_seven} = 4'h0;
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    foreach (rows[i]) begin
      bus(1'b1, rows[i].adr, rows[i].wd);
      bus(1'b0, rows[i].adr, 8'h00);
      chk(q, {24'h00_0000, rows[i].rd});
    end
    $display("test register rows done");
    bus(1'b1, 4'h0, 8'h5F);
    bus(1'b1, 4'h4, 8'hEC);
    @(posedge sys_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    bus(1'b0, 4'h0, 8'h00);
    chk(q, 32'h0000_0000);
    bus(1'b0, 4'h4, 8'h00);
    chk(q, 32'h0000_0000);
    bus(1'b0, 4'hC, 8'h00);
    chk(q & 32'h0000_00FC, 32'h0000_00C0);
    bus(1'b0, 4'h2, 8'h00);
    chk(bus_err, 1'b1);
    $display("test reset done");
    port_dir_bit_six <= 1'b1;
    port_dir_bit_seven <= 1'b1;
    repeat (6) @(posedge sys_clk);
    chk({serial_tx_pin_oe_n, serial_rx_pin_oe_n, port_in_six, port_in_seven}, 4'h0);
    bus(1'b1, 4'h0, 8'h40);
    repeat (3) @(posedge sys_clk);
    chk({serial_tx_pin_oe_n, serial_rx_pin_oe_n}, 2'b11);
    port_dir_bit_six <= 1'b0;
    port_dir_bit_seven <= 1'b0;
    $display("test pin steering done");
    bus(1'b1, 4'h0, 8'hE0); // loop with infrared on
    bus(1'b1, 4'h4, 8'h2C);
    bus(1'b1, 4'h8, 8'hA5);
    n = 0;
    while (rx_irq !== 1'b1 && n < 1000) begin
      @(posedge sys_clk);
      n++;
    end
    chk(rx_irq, 1'b1);
    bus(1'b0, 4'h8, 8'h00);
    chk(q, 32'h0000_00A5);
    repeat (2) @(posedge sys_clk);
    chk(rx_irq, 1'b0);
    $display("test loop done");
    bus(1'b1, 4'h4, 8'h04);
    foreach (prow[i]) begin
      bus(1'b1, 4'h0, {7'h21, prow[i][9]});
      rem.send({1'b0, prow[i][8:1]}, 8, 16);
      repeat (4) @(posedge sys_clk);
      bus(1'b0, 4'hC, 8'h00);
      chk(q[3], prow[i][0]);
      bus(1'b0, 4'h8, 8'h00);
      chk(q[6:0], prow[i][7:1]);
    end
    bus(1'b1, 4'h0, 8'h50);
    rem.send(9'h1A5, 9, 16);
    repeat (4) @(posedge sys_clk);
    bus(1'b0, 4'hC, 8'h00);
    chk(q[1], 1'b1);
    bus(1'b0, 4'h8, 8'h00);
    chk(q, 32'h0000_00A5);
    // address-mark wakeup: a character with msb clear stays unseen
    bus(1'b1, 4'h0, 8'h48);
    bus(1'b1, 4'h4, 8'h06);
    rem.send(9'h012, 8, 16);
    repeat (4) @(posedge sys_clk);
    bus(1'b0, 4'hC, 8'h00);
    chk(q[5], 1'b0);
    rem.send(9'h093, 8, 16);
    repeat (4) @(posedge sys_clk);
    bus(1'b0, 4'h4, 8'h00);
    chk(q, 32'h0000_0004);
    bus(1'b0, 4'h8, 8'h00);
    chk(q, 32'h0000_0093);
    repeat (200) @(posedge sys_clk);
    bus(1'b0, 4'hC, 8'h00);
    chk(q[4], 1'b1);
    $display("test receive frames done");
    bus(1'b1, 4'h0, 8'h40);
    bus(1'b1, 4'h4, 8'h88);
    repeat (2) @(posedge sys_clk);
    chk(tx_irq, 1'b1);
    bus(1'b1, 4'h8, 8'h55);
    bus(1'b0, 4'hC, 8'h00);
    // the byte moves to the shifter at once: empty again, frame in progress
    chk(q[7:6], 2'b10);
    repeat (7) @(posedge sys_clk);
    for (int k = 0; k < 10; k++) begin
      q[k] = tx_wire;
      repeat (16) @(posedge sys_clk);
    end
    chk(q[9:0], {1'b1, 8'h55, 1'b0});
    poll_tc();
    bus(1'b1, 4'h0, 8'h60);
    bus(1'b1, 4'h8, 8'h0F);
    poll_tc();
    bus(1'b1, 4'h8, 8'h33);
    bus(1'b1, 4'h0, 8'h00);
    bus(1'b0, 4'hC, 8'h00);
    chk(q[7:6], 2'b11);
    $display("test transmit done");
    print_verdict();
  end
endmodule // tb_sci_pin_and_frame_control
`default_nettype wire
